// File: design/fthr_pkg.sv
// package: offsets, field positions, reset values for the threshold and fill-level bank
// assumes: single clock, 32-bit word ports, byte offsets word aligned
package fthr_pkg;

  localparam int unsigned DATA_W            = 32;
  localparam int unsigned CTRL_ADDR_W       = 4;
  localparam int unsigned FILL_ADDR_W       = 10;

  // control port byte offsets
  localparam logic [CTRL_ADDR_W-1:0] OFS_PRI_FULL  = 4'h0;
  localparam logic [CTRL_ADDR_W-1:0] OFS_PRI_EMPTY = 4'h4;
  localparam logic [CTRL_ADDR_W-1:0] OFS_SEC_FULL  = 4'h8;
  localparam logic [CTRL_ADDR_W-1:0] OFS_SEC_EMPTY = 4'hC;

  // status bit positions
  localparam int unsigned BIT_PRI = 0;
  localparam int unsigned BIT_SEC = 1;

  // fill-level port: channel n at byte n*4
  localparam int unsigned FILL_STRIDE_SH = 2;

  // reset values
  localparam logic [DATA_W-1:0] RST_WATERMARK = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_OCCUPANCY = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_ZERO     = 32'h0000_0000;

endpackage : fthr_pkg

// File: design/fthr_cmp_if.sv
// interface: fill level and watermarks toward the comparator, status back
// assumes: same clock as the register bank
`timescale 1ns/1ps
interface fthr_cmp_if;
  import fthr_pkg::*;
  logic [DATA_W-1:0] level;
  logic [DATA_W-1:0] pri_full;
  logic [DATA_W-1:0] pri_empty;
  logic [DATA_W-1:0] sec_full;
  logic [DATA_W-1:0] sec_empty;
  logic [1:0]        full_hit;
  logic [1:0]        empty_hit;
  modport bank (output level, pri_full, pri_empty, sec_full, sec_empty,
                input full_hit, empty_hit);
  modport cmp  (input level, pri_full, pri_empty, sec_full, sec_empty,
                output full_hit, empty_hit);
endinterface : fthr_cmp_if

// File: design/fthr_cmp.sv
// comparator: raw almost-full / almost-empty decisions
// assumes: inputs are registered by the bank; result is registered there too
`timescale 1ns/1ps
module fthr_cmp
  import fthr_pkg::*;
#(
  parameter int unsigned NUM_FULL  = 2,
  parameter int unsigned NUM_EMPTY = 2
)(
  fthr_cmp_if.cmp c
);
  always_comb
  begin
    c.full_hit  = 2'h0;
    c.empty_hit = 2'h0;
    if (NUM_FULL >= 1)
      c.full_hit[BIT_PRI] = (c.level >= c.pri_full);   // see [RULE_01]
    if (NUM_FULL == 2)
      c.full_hit[BIT_SEC] = (c.level >= c.sec_full);   // see [RULE_03] see [RULE_08]
    if (NUM_EMPTY >= 1)
      c.empty_hit[BIT_PRI] = (c.level <= c.pri_empty); // see [RULE_02]
    if (NUM_EMPTY == 2)
      c.empty_hit[BIT_SEC] = (c.level <= c.sec_empty); // see [RULE_04]
  end
endmodule : fthr_cmp

// File: design/fthr_regs.sv
// register bank: watermark control port, per-channel occupancy port, status outputs
// assumes: occupancy counts and selected level come from FIFO logic on core_clk_i
`timescale 1ns/1ps

// Function
// [RULE_01] almost-full bit 0 high while level at or above primary full watermark
// [RULE_02] almost-empty bit 0 high while level at or below primary empty watermark
// [RULE_03] almost-full bit 1 high while level at or above secondary full watermark
// [RULE_04] almost-empty bit 1 high while level at or below secondary empty watermark
// [RULE_05] one read-only occupancy word per channel at byte n*4, reset zero
// [RULE_06] occupancy register count equals configured channel count
// [RULE_07] master writes watermarks on control port, reads occupancy on separate port
// [RULE_08] secondary full watermark and its bit exist only with two full thresholds
// [RULE_09] fill-level port exists only when fill-level option is one
// [RULE_10] status bits drop when comparison fails, re-evaluated every cycle
module fthr_regs
  import fthr_pkg::*;
#(
  parameter int unsigned NUM_CH    = 4,
  parameter int unsigned NUM_FULL  = 2,
  parameter int unsigned NUM_EMPTY = 2,
  parameter bit          USE_FILL  = 1'b1
)(
  // clock, reset, enable
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        clk_en_i,
  // fifo side
  input  wire logic [NUM_CH*DATA_W-1:0]    ch_occupancy_i,
  input  wire logic [DATA_W-1:0]           cur_level_i,
  // control port
  input  wire logic [fthr_pkg::CTRL_ADDR_W-1:0] ctrl_addr_i,
  input  wire logic                        ctrl_write_i,
  input  wire logic                        ctrl_read_i,
  input  wire logic [fthr_pkg::DATA_W-1:0] ctrl_wdata_i,
  output logic      [fthr_pkg::DATA_W-1:0] ctrl_rdata_o,
  // fill-level port
  input  wire logic [fthr_pkg::FILL_ADDR_W-1:0] fill_addr_i,
  input  wire logic                        fill_read_i,
  output logic      [fthr_pkg::DATA_W-1:0] fill_rdata_o,
  // status outputs
  output logic      [1:0]                  almost_full_o,
  output logic      [1:0]                  almost_empty_o
);
  import fthr_pkg::*;

  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic [DATA_W-1:0]          pri_full;
    logic [DATA_W-1:0]          pri_empty;
    logic [DATA_W-1:0]          sec_full;
    logic [DATA_W-1:0]          sec_empty;
    logic [NUM_CH*DATA_W-1:0]   occ;
    logic [DATA_W-1:0]          level;
    logic [DATA_W-1:0]          ctrl_rdata;
    logic [DATA_W-1:0]          fill_rdata;
    logic [1:0]                 afull;
    logic [1:0]                 aempty;
  } fthr_state_type;

  fthr_state_type s_q;
  fthr_state_type s_d;

  fthr_cmp_if cmp_bus ();

  // ******************************
  // comparator
  // ******************************
  assign cmp_bus.level     = s_q.level;
  assign cmp_bus.pri_full  = s_q.pri_full;
  assign cmp_bus.pri_empty = s_q.pri_empty;
  assign cmp_bus.sec_full  = s_q.sec_full;
  assign cmp_bus.sec_empty = s_q.sec_empty;

  fthr_cmp #(
    .NUM_FULL  (NUM_FULL),
    .NUM_EMPTY (NUM_EMPTY)
  ) u_cmp (
    .c (cmp_bus.cmp)
  );

  // ******************************
  // next state
  // ******************************
  function automatic logic [DATA_W-1:0] fthr_occ_word(
    input logic [NUM_CH*DATA_W-1:0] occ,
    input logic [FILL_ADDR_W-1:0]   addr
  );
    logic [FILL_ADDR_W-1:0] idx;
    logic [DATA_W-1:0]      w;
    idx = addr >> FILL_STRIDE_SH;
    w   = READ_ZERO;
    for (int i = 0; i < NUM_CH; i++)
      if (idx == FILL_ADDR_W'(i))
        w = occ[i*DATA_W +: DATA_W];                   // see [RULE_05] see [RULE_06]
    return w;
  endfunction : fthr_occ_word

  always_comb
  begin
    s_d        = s_q;
    s_d.level  = cur_level_i;
    s_d.afull  = cmp_bus.full_hit;                     // see [RULE_10]
    s_d.aempty = cmp_bus.empty_hit;                    // see [RULE_10]
    if (USE_FILL)
      s_d.occ = ch_occupancy_i;                        // see [RULE_09]
    else
      s_d.occ = '0;
    if (ctrl_write_i)
    begin
      case (ctrl_addr_i)
        OFS_PRI_FULL:  if (NUM_FULL >= 1) s_d.pri_full = ctrl_wdata_i;
        OFS_PRI_EMPTY: if (NUM_EMPTY >= 1) s_d.pri_empty = ctrl_wdata_i;
        OFS_SEC_FULL:  if (NUM_FULL == 2) s_d.sec_full = ctrl_wdata_i;  // see [RULE_08]
        OFS_SEC_EMPTY: if (NUM_EMPTY == 2) s_d.sec_empty = ctrl_wdata_i;
        default: ;
      endcase
    end
    if (ctrl_read_i)
    begin
      case (ctrl_addr_i)
        OFS_PRI_FULL:  s_d.ctrl_rdata = s_q.pri_full;
        OFS_PRI_EMPTY: s_d.ctrl_rdata = s_q.pri_empty;
        OFS_SEC_FULL:  s_d.ctrl_rdata = s_q.sec_full;
        OFS_SEC_EMPTY: s_d.ctrl_rdata = s_q.sec_empty;
        default:       s_d.ctrl_rdata = READ_ZERO;
      endcase
    end
    // separate port; writes have no path here by construction
    if (fill_read_i && USE_FILL)
      s_d.fill_rdata = fthr_occ_word(s_q.occ, fill_addr_i);  // see [RULE_07]
  end

  // ******************************
  // registers
  // ******************************
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q.pri_full   <= RST_WATERMARK;
      s_q.pri_empty  <= RST_WATERMARK;
      s_q.sec_full   <= RST_WATERMARK;
      s_q.sec_empty  <= RST_WATERMARK;
      s_q.occ        <= '0;
      s_q.level      <= READ_ZERO;
      s_q.ctrl_rdata <= READ_ZERO;
      s_q.fill_rdata <= RST_OCCUPANCY;
      s_q.afull      <= 2'h0;
      s_q.aempty     <= 2'h0;
    end
    else if (clk_en_i)
    begin
      s_q <= s_d;
    end
  end

  assign ctrl_rdata_o   = s_q.ctrl_rdata;
  assign fill_rdata_o   = s_q.fill_rdata;
  assign almost_full_o  = s_q.afull;
  assign almost_empty_o = s_q.aempty;

endmodule : fthr_regs

// File: tb/fthr_chk_sva.sv
// checker: status and read-back timing at the bank ports
// assumes: clk_en_i held high by the bench
`timescale 1ns/1ps
module fthr_chk
  import fthr_pkg::*;
#(parameter int unsigned NUM_CH = 4)
(
  input wire logic core_clk_i, rst_i, ctrl_write_i, ctrl_read_i, fill_read_i,
  input wire logic [NUM_CH*DATA_W-1:0] ch_occupancy_i,
  input wire logic [DATA_W-1:0] cur_level_i, ctrl_wdata_i, ctrl_rdata_o, fill_rdata_o,
  input wire logic [CTRL_ADDR_W-1:0] ctrl_addr_i,
  input wire logic [FILL_ADDR_W-1:0] fill_addr_i,
  input wire logic [1:0] almost_full_o, almost_empty_o
);
  logic [DATA_W-1:0] wm_q [4];
  logic [NUM_CH*DATA_W-1:0] oc_q;
  logic [1:0] ag_q;
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i)
    begin
      wm_q <= '{default: '0};
      oc_q <= '0;
      ag_q <= 2'h0;
    end
    else
    begin
      oc_q <= ch_occupancy_i;
      ag_q <= ag_q | {ag_q[0], 1'b1};
      if (ctrl_write_i && ctrl_addr_i[1:0] == 2'h0)
        wm_q[ctrl_addr_i[3:2]] <= ctrl_wdata_i;
    end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // status pipeline needs two edges past reset before it is meaningful
  chk_pri_full: assert property (ag_q == 2'h3 |->
    almost_full_o[0] == ($past(cur_level_i, 2) >= $past(wm_q[0]))) else $error("pri full");
  chk_pri_empty: assert property (ag_q == 2'h3 |->
    almost_empty_o[0] == ($past(cur_level_i, 2) <= $past(wm_q[1]))) else $error("pri empty");
  chk_sec_full: assert property (ag_q == 2'h3 |->
    almost_full_o[1] == ($past(cur_level_i, 2) >= $past(wm_q[2]))) else $error("sec full");
  chk_sec_empty: assert property (ag_q == 2'h3 |->
    almost_empty_o[1] == ($past(cur_level_i, 2) <= $past(wm_q[3]))) else $error("sec empty");
  chk_status_hold: assert property (
    (ag_q == 2'h3 && !ctrl_write_i && $stable(cur_level_i))[*4] |->
    $stable(almost_full_o) && $stable(almost_empty_o)) else $error("status moved");
  chk_ctrl_readback: assert property (ctrl_read_i |=> ctrl_rdata_o ==
    ($past(ctrl_addr_i[1:0]) == 2'h0 ? $past(wm_q[ctrl_addr_i[3:2]]) : READ_ZERO))
    else $error("ctrl read");
  chk_fill_read: assert property (fill_read_i && fill_addr_i < NUM_CH*4 |=>
    fill_rdata_o == $past(oc_q[fill_addr_i[9:2]*DATA_W +: DATA_W])) else $error("fill read");
  chk_fill_beyond: assert property (fill_read_i && fill_addr_i >= NUM_CH*4 |=>
    fill_rdata_o == READ_ZERO) else $error("fill beyond");
  cover property (almost_full_o == 2'h3);
  cover property (almost_empty_o == 2'h3);
  cover property (fill_read_i && fill_addr_i >= NUM_CH*4);
endmodule : fthr_chk
bind fthr_regs fthr_chk #(.NUM_CH(NUM_CH)) u_chk (.core_clk_i, .rst_i, .ctrl_write_i,
  .ctrl_read_i, .fill_read_i, .ch_occupancy_i, .cur_level_i, .ctrl_wdata_i, .ctrl_rdata_o,
  .fill_rdata_o, .ctrl_addr_i, .fill_addr_i, .almost_full_o, .almost_empty_o);

// File: tb/fthr_host.sv
// host model: master on the control and fill-level ports
// assumes: one request at a time, bench calls wr and rd
`timescale 1ns/1ps
module fthr_host
  import fthr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic [DATA_W-1:0] rdata_i, frdata_i,
  output logic [CTRL_ADDR_W-1:0] addr_o = '0,
  output logic wr_o = 1'b0, rd_o = 1'b0, frd_o = 1'b0,
  output logic [DATA_W-1:0] wdata_o = '0,
  output logic [FILL_ADDR_W-1:0] faddr_o = '0
);
  // watermarks go out on the control port only
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i) #1;
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(posedge clk_i) #1;
    wr_o    = 1'b0;
    wdata_o = ~d;
  endtask : wr
  // occupancy comes back on its own port
  task automatic rd(input bit f, input logic [9:0] a, output logic [31:0] q);
    @(posedge clk_i) #1;
    addr_o  = a[3:0];
    faddr_o = a;
    rd_o    = !f;
    frd_o   = f;
    @(posedge clk_i) #1;
    q     = f ? frdata_i : rdata_i;
    rd_o  = 1'b0;
    frd_o = 1'b0;
  endtask : rd
endmodule : fthr_host

// File: tb/tb_fthr_regs.sv
// bench: random watermarks, levels and occupancy against an integer model
// assumes: host model drives both memory-mapped ports
`timescale 1ns/1ps
module tb_fthr_regs;
  import fthr_pkg::*;
  logic core_clk_i = 1'b0, rst_i = 1'b1, cw, cr, fr;
  logic [4*DATA_W-1:0] occ = '0;
  logic [DATA_W-1:0] lvl = '0, cwd, crd, frd, got;
  logic [3:0] ca;
  logic [9:0] fa;
  logic [1:0] af, ae;
  int fails = 0, total_checks = 0, cyc = 0, k;
  int wm [4];
  always #20 core_clk_i = ~core_clk_i;
  fthr_regs DUT (.core_clk_i, .rst_i, .clk_en_i(1'b1), .ch_occupancy_i(occ),
    .cur_level_i(lvl), .ctrl_addr_i(ca), .ctrl_write_i(cw), .ctrl_read_i(cr),
    .ctrl_wdata_i(cwd), .ctrl_rdata_o(crd), .fill_addr_i(fa), .fill_read_i(fr),
    .fill_rdata_o(frd), .almost_full_o(af), .almost_empty_o(ae));
  fthr_host host (.clk_i(core_clk_i), .rdata_i(crd), .frdata_i(frd), .addr_o(ca),
    .wr_o(cw), .rd_o(cr), .frd_o(fr), .wdata_o(cwd), .faddr_o(fa));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_stat(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %0t status got %h exp %h", $time, g, e);
    end
  endtask : cmp_stat
  task automatic cmp_fill(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %0t fill got %h exp %h", $time, g, e);
    end
  endtask : cmp_fill
  task automatic wrap_up;
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  always @(posedge core_clk_i)
    if (++cyc > 4000)
    begin
      fails++;
      wrap_up;
    end
  initial
  begin
    void'($urandom(32'h4938));
    repeat (12) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    for (int r = 0; r < 4; r++)
    begin
      host.rd(1'b0, 10'(r * 4), got);
      cmp(got, '0);
    end
    for (int n = 0; n < 30; n++)
    begin
      for (int r = 0; r < 4; r++)
      begin
        wm[r] = $urandom_range(15);
        host.wr(4'(r * 4), wm[r]);
      end
      host.wr(4'h2, 32'hFFFF_FFFF);
      @(posedge core_clk_i) #1;
      lvl = $urandom_range(15);
      occ = {$urandom, $urandom, $urandom, $urandom};
      repeat (6) @(posedge core_clk_i);
      #1;
      cmp_stat(32'(af), 32'({lvl >= wm[2], lvl >= wm[0]}));
      cmp_stat(32'(ae), 32'({lvl <= wm[3], lvl <= wm[1]}));
      for (int r = 0; r < 5; r++)
      begin
        host.rd(1'b0, (r < 4) ? 10'(r * 4) : 10'h2, got);
        cmp(got, (r < 4) ? wm[r] : 0);
      end
      k = $urandom_range(4);
      host.rd(1'b1, 10'(k * 4), got);
      cmp_fill(got, (k < 4) ? occ[k*32 +: 32] : '0);
    end
    wrap_up;
  end
endmodule : tb_fthr_regs
